// ### crc_pkg.sv
// Package of constants and types for the cable reflectometry controller
package crc_pkg;

	// ------------------------------------------------------------------
	// Clock
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;

	// ------------------------------------------------------------------
	// Register map, diagnostic page
	// ------------------------------------------------------------------
	localparam logic [2:0] DIAG_PAGE = 3'h2;
	localparam logic [4:0] REG_CTRL_OFS = 5'h16;
	localparam logic [4:0] REG_WIN_OFS = 5'h17;
	localparam logic [4:0] REG_PEAK_OFS = 5'h18;
	localparam logic [4:0] REG_THR_OFS = 5'h19;

	// ------------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------------
	localparam int CTRL_EN_BIT = 15;
	localparam int CTRL_FAST_BIT = 14;
	localparam int CTRL_TXPAIR_BIT = 13;
	localparam int CTRL_MONPAIR_BIT = 12;
	localparam int CTRL_SEND_BIT = 11;
	localparam int CTRL_WID_LSB = 8;
	localparam int CTRL_MIN_BIT = 7;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] CTRL_STORE_MASK = 16'hf780;

	// ------------------------------------------------------------------
	// Window register fields
	// ------------------------------------------------------------------
	localparam int WIN_START_LSB = 8;
	localparam int WIN_STOP_LSB = 0;
	localparam logic [15:0] WIN_RST = 16'h00ff;
	localparam logic [7:0] TIMER_LAST = 8'hff;

	// ------------------------------------------------------------------
	// Slow-driver link pulse timing
	// ------------------------------------------------------------------
	localparam int LINK_SHORT_NS = 50;
	localparam int LINK_LONG_NS = 100;
	localparam logic [2:0] LINK_SHORT_CYC =
		3'((LINK_SHORT_NS / CLK_PERIOD_NS) < 1 ? 1 : LINK_SHORT_NS / CLK_PERIOD_NS);
	localparam logic [2:0] LINK_LONG_CYC =
		3'((LINK_LONG_NS / CLK_PERIOD_NS) < 1 ? 1 : LINK_LONG_NS / CLK_PERIOD_NS);
	localparam logic [2:0] LINK_LONG_MIN_WID = 3'h4;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_RUN = 1'b1
	} crc_run_t;

endpackage : crc_pkg

// ### crc_monitor.sv
// Peak and threshold-crossing tracker for reflectometry samples
`timescale 1ns/100ps
module crc_monitor
	import crc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Run control
	input wire logic clear_i,
	input wire logic qual_i,
	input wire logic min_mode_i,
	input wire logic [7:0] tick_i,
	// Sample path
	input wire logic signed [7:0] sample_i,
	input wire logic signed [7:0] thr_level_i,
	// Results
	output logic [7:0] peak_val_o,
	output logic [7:0] peak_time_o,
	output logic peak_seen_o,
	output logic [7:0] thr_val_o,
	output logic [7:0] thr_time_o,
	output logic thr_hit_o
);

	// ------------------------------------------------------------------
	// Comparisons
	// ------------------------------------------------------------------
	// Strict compare keeps the time of the first occurrence of the peak
	wire logic signed [7:0] peak_s = peak_val_o;
	wire logic beats_peak = min_mode_i ? (sample_i < peak_s) : (sample_i > peak_s);
	wire logic peak_upd = qual_i & (~peak_seen_o | beats_peak);
	wire logic over_thr = min_mode_i ? (sample_i < thr_level_i) : (sample_i > thr_level_i);
	wire logic thr_upd = qual_i & ~thr_hit_o & over_thr;

	// ------------------------------------------------------------------
	// Result registers
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || clear_i) begin
			peak_val_o <= 8'h00;
			peak_time_o <= 8'h00;
			peak_seen_o <= 1'b0;
		end else if (peak_upd) begin
			peak_val_o <= sample_i;
			peak_time_o <= tick_i;
			peak_seen_o <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || clear_i) begin
			thr_val_o <= 8'h00;
			thr_time_o <= 8'h00;
			thr_hit_o <= 1'b0;
		end else if (thr_upd) begin
			thr_val_o <= sample_i;
			thr_time_o <= tick_i;
			thr_hit_o <= 1'b1;
		end
	end

endmodule : crc_monitor

// ### crc_ctrl.sv
// Cable reflectometry controller: registers, pulse generator, timed monitor
//
// Behaviour
// - Control register at 16h, window register at 17h, diagnostic page 2.
// - Control bit 15 suspends link and gives both line drivers to this logic.
// - Writing control bit 11 launches one pulse and starts the monitor.
// - Control bit 14 clear: slow-driver link pulses; set: fast-driver data pulses.
// - Control bits 10:8 give fast pulse width 0..7 clocks; slow pulses are long from 4 up; zero sends no pulse.
// - Control bit 13 picks pulse pair: zero transmit pair, one receive pair.
// - Control bit 7 clear tracks most positive sample; set tracks most negative.
// - Control bit 12 picks monitored pair: zero transmit pair, one receive pair.
// - Samples qualify only from window start count through window stop count.
// - Window resets to start 0, stop 255, counted in sample clocks.
// - Peak result reads at 18h, threshold result at 19h, same page.
// - Timer runs from launch; first peak or threshold time is recorded.
// - Fast-driver pulses alternate positive and negative polarity.
// - Zero width still runs the monitor to capture a baseline.
// - Slow-driver link pulses last either 40 ns (2 clocks) or 100 ns (5 clocks).
`timescale 1ns/100ps
module crc_ctrl
	import crc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Management register port
	input wire logic [2:0] reg_page_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	// Converter samples from the two pairs, asynchronous to this clock
	input wire logic [7:0] adc_tx_pair_i,
	input wire logic [7:0] adc_rx_pair_i,
	// Threshold level for the crossing detector
	input wire logic [7:0] thr_level_i,
	// Line driver control
	output logic link_suspend_o,
	output logic slow_line_driver_own_o,
	output logic fast_line_driver_own_o,
	output logic slow_line_driver_pulse_o,
	output logic fast_line_driver_pos_o,
	output logic fast_line_driver_neg_o,
	output logic pulse_pair_rx_o,
	// Status
	output logic busy_o
);

	// ------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------
	logic [15:0] ctrl_r;
	logic [15:0] win_r;
	crc_run_t run_r;
	crc_run_t run_nxt;

	wire logic page_hit = (reg_page_i == DIAG_PAGE);
	wire logic sel_ctrl = page_hit & (reg_addr_i == REG_CTRL_OFS);
	wire logic sel_win = page_hit & (reg_addr_i == REG_WIN_OFS);
	wire logic sel_peak = page_hit & (reg_addr_i == REG_PEAK_OFS);
	wire logic sel_thr = page_hit & (reg_addr_i == REG_THR_OFS);

	wire logic en_bit = ctrl_r[CTRL_EN_BIT];
	wire logic fast_bit = ctrl_r[CTRL_FAST_BIT];
	wire logic min_bit = ctrl_r[CTRL_MIN_BIT];
	wire logic mon_rx_bit = ctrl_r[CTRL_MONPAIR_BIT];
	wire logic [2:0] wid = ctrl_r[CTRL_WID_LSB +: 3];
	wire logic [7:0] win_start = win_r[WIN_START_LSB +: 8];
	wire logic [7:0] win_stop = win_r[WIN_STOP_LSB +: 8];

	// A launch needs the enable bit set in the same write as the send bit
	wire logic wr_ctrl = reg_wr_i & sel_ctrl;
	wire logic launch = wr_ctrl & reg_wdata_i[CTRL_SEND_BIT] & reg_wdata_i[CTRL_EN_BIT]
		& (run_r == ST_IDLE);

	// ------------------------------------------------------------------
	// Control and window registers
	// ------------------------------------------------------------------
	// Send bit reads back as busy; it drops by itself when the run ends
	wire logic [15:0] ctrl_store = reg_wdata_i & CTRL_STORE_MASK;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ctrl_r <= CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= ctrl_store;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			win_r <= WIN_RST;
		end else if (reg_wr_i && sel_win) begin
			win_r <= reg_wdata_i;
		end
	end

	// ------------------------------------------------------------------
	// Line ownership
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			link_suspend_o <= 1'b0;
			slow_line_driver_own_o <= 1'b0;
			fast_line_driver_own_o <= 1'b0;
			pulse_pair_rx_o <= 1'b0;
		end else begin
			link_suspend_o <= en_bit;
			slow_line_driver_own_o <= en_bit;
			fast_line_driver_own_o <= en_bit;
			pulse_pair_rx_o <= ctrl_r[CTRL_TXPAIR_BIT];
		end
	end

	// ------------------------------------------------------------------
	// Run timer
	// ------------------------------------------------------------------
	logic [7:0] timer_r;
	wire logic run_last = (timer_r == win_stop) | (timer_r == TIMER_LAST);
	wire logic in_win = (timer_r >= win_start) & (timer_r <= win_stop);
	wire logic qual = (run_r == ST_RUN) & in_win;

	always_comb begin
		run_nxt = run_r;
		unique case (run_r)
			ST_IDLE: if (launch) run_nxt = ST_RUN;
			ST_RUN: if (run_last || !en_bit) run_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			run_r <= ST_IDLE;
			timer_r <= 8'h00;
		end else begin
			run_r <= run_nxt;
			timer_r <= (run_r == ST_RUN) ? timer_r + 8'h01 : 8'h00;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			busy_o <= 1'b0;
		end else begin
			busy_o <= (run_nxt == ST_RUN);
		end
	end

	// ------------------------------------------------------------------
	// Pulse generator
	// ------------------------------------------------------------------
	// Width is sampled from the launching write so a late edit cannot stretch it
	wire logic [2:0] new_wid = reg_wdata_i[CTRL_WID_LSB +: 3];
	wire logic new_fast = reg_wdata_i[CTRL_FAST_BIT];
	wire logic [2:0] slow_len = (new_wid >= LINK_LONG_MIN_WID) ? LINK_LONG_CYC
		: LINK_SHORT_CYC;
	wire logic [2:0] pulse_len = (new_wid == 3'h0) ? 3'h0 : (new_fast ? new_wid : slow_len);
	logic [2:0] pulse_cnt_r;
	logic pulse_fast_r;
	logic fast_pol_r;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			pulse_cnt_r <= 3'h0;
			pulse_fast_r <= 1'b0;
		end else if (launch) begin
			pulse_cnt_r <= pulse_len;
			pulse_fast_r <= new_fast;
		end else if (pulse_cnt_r != 3'h0) begin
			pulse_cnt_r <= pulse_cnt_r - 3'h1;
		end
	end

	// Polarity flips on every sent fast pulse, not on baseline runs
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			fast_pol_r <= 1'b0;
		end else if (launch && new_fast && new_wid != 3'h0) begin
			fast_pol_r <= ~fast_pol_r;
		end
	end

	wire logic pulse_on = (pulse_cnt_r != 3'h0) & en_bit;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			slow_line_driver_pulse_o <= 1'b0;
			fast_line_driver_pos_o <= 1'b0;
			fast_line_driver_neg_o <= 1'b0;
		end else begin
			slow_line_driver_pulse_o <= pulse_on & ~pulse_fast_r;
			fast_line_driver_pos_o <= pulse_on & pulse_fast_r & fast_pol_r;
			fast_line_driver_neg_o <= pulse_on & pulse_fast_r & ~fast_pol_r;
		end
	end

	// ------------------------------------------------------------------
	// Sample synchronisers and pair select
	// ------------------------------------------------------------------
	logic [7:0] adc_tx_m_r;
	logic [7:0] adc_tx_s_r;
	logic [7:0] adc_rx_m_r;
	logic [7:0] adc_rx_s_r;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			adc_tx_m_r <= 8'h00;
			adc_tx_s_r <= 8'h00;
			adc_rx_m_r <= 8'h00;
			adc_rx_s_r <= 8'h00;
		end else begin
			adc_tx_m_r <= adc_tx_pair_i;
			adc_tx_s_r <= adc_tx_m_r;
			adc_rx_m_r <= adc_rx_pair_i;
			adc_rx_s_r <= adc_rx_m_r;
		end
	end

	wire logic [7:0] mon_sample = mon_rx_bit ? adc_rx_s_r : adc_tx_s_r;

	// ------------------------------------------------------------------
	// Monitor
	// ------------------------------------------------------------------
	logic [7:0] peak_val;
	logic [7:0] peak_time;
	logic [7:0] thr_val;
	logic [7:0] thr_time;
	logic thr_hit;

	crc_monitor u_monitor (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.clear_i(launch),
		.qual_i(qual),
		.min_mode_i(min_bit),
		.tick_i(timer_r),
		.sample_i(mon_sample),
		.thr_level_i(thr_level_i),
		.peak_val_o(peak_val),
		.peak_time_o(peak_time),
		.peak_seen_o(),
		.thr_val_o(thr_val),
		.thr_time_o(thr_time),
		.thr_hit_o(thr_hit)
	);

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	wire logic [15:0] ctrl_view = {ctrl_r[15:12], (run_r == ST_RUN), ctrl_r[10:0]};
	wire logic [15:0] rd_mux = sel_ctrl ? ctrl_view
		: sel_win ? win_r
		: sel_peak ? {peak_time, peak_val}
		: sel_thr ? {thr_time, thr_val}
		: 16'h0000;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rd_mux;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	logic [2:0] hi_cnt_r;
	logic [2:0] exp_len_r;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			hi_cnt_r <= 3'h0;
			exp_len_r <= 3'h0;
		end else begin
			if (launch) exp_len_r <= pulse_len;
			hi_cnt_r <= (slow_line_driver_pulse_o | fast_line_driver_pos_o
				| fast_line_driver_neg_o) ? hi_cnt_r + 3'h1 : 3'h0;
		end
	end

	sequence s_launch_fast;
		launch && new_fast && (new_wid != 3'h0);
	endsequence

	sequence s_pulse_start;
		##2 (fast_line_driver_pos_o || fast_line_driver_neg_o);
	endsequence

	a_default_window: assert property (@(posedge ref_clk_i)
		!rst_n_i |=> (win_r == WIN_RST))
		else $error("window not at reset value");

	a_suspend_drivers: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$rose(en_bit) |=> (link_suspend_o && slow_line_driver_own_o && fast_line_driver_own_o))
		else $error("drivers not handed over after enable");

	a_launch_clears: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		launch |=> (peak_val == 8'h00 && thr_val == 8'h00 && !thr_hit))
		else $error("results not cleared by launch");

	a_launch_runs: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		launch |=> (run_r == ST_RUN && timer_r == 8'h00) ##1 busy_o)
		else $error("launch did not start monitor");

	a_zero_width: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(launch && new_wid == 3'h0) |=> (!slow_line_driver_pulse_o && !fast_line_driver_pos_o
		&& !fast_line_driver_neg_o && run_r == ST_RUN)[*2])
		else $error("zero width sent a pulse or skipped monitor");

	a_fast_alternate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_launch_fast |-> s_pulse_start ##0 (fast_line_driver_pos_o != $past(fast_pol_r, 2)))
		else $error("fast pulse polarity did not alternate");

	a_pulse_length: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$fell(slow_line_driver_pulse_o || fast_line_driver_pos_o || fast_line_driver_neg_o)
		&& en_bit |-> ($past(hi_cnt_r) + 3'h1 == exp_len_r))
		else $error("pulse length differs from programmed width");

	a_window_qual: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(run_r == ST_RUN && timer_r < win_start) |=> ($stable(peak_val) && $stable(thr_val)))
		else $error("sample qualified outside window");

	a_run_ends: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(run_r == ST_RUN && timer_r == win_stop) |=> (run_r == ST_IDLE) ##1 !busy_o)
		else $error("run did not end at window stop");

	a_thr_time: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$rose(thr_hit) |-> (thr_time == $past(timer_r) && $past(qual)))
		else $error("threshold time not taken from timer");

	a_pair_select: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(run_r == ST_RUN) |-> (mon_sample == (mon_rx_bit ? $past(adc_rx_pair_i, 2)
		: $past(adc_tx_pair_i, 2))))
		else $error("monitor pair mismatch");

endmodule : crc_ctrl

// ### crc_line_model.sv
// Cable and converter model: outgoing pulse plus one delayed echo on each pair
`timescale 1ns/100ps
module crc_line_model #(
	parameter int ECHO_DLY = 20
) (
	// Clock and run reference
	input wire logic ref_clk_i,
	input wire logic busy_i,
	// Line driver activity
	input wire logic slow_pulse_i,
	input wire logic fast_pos_i,
	input wire logic fast_neg_i,
	input wire logic pair_rx_i,
	// Converter samples
	output logic [7:0] adc_tx_o,
	output logic [7:0] adc_rx_o
);
	int cnt_r = 0;
	logic [7:0] drive_w;
	logic echo_w;

	always @(posedge ref_clk_i) begin
		cnt_r <= (busy_i === 1'b1) ? cnt_r + 1 : 0;
	end

	assign echo_w = (cnt_r == ECHO_DLY);
	assign drive_w = fast_neg_i ? 8'h90 : ((fast_pos_i || slow_pulse_i) ? 8'h70 : 8'h00);
	// The outgoing pulse is seen only on the pair that carries it
	assign adc_tx_o = (drive_w != 8'h00 && !pair_rx_i) ? drive_w : (echo_w ? 8'h40 : 8'h02);
	// Echo is inverted on the receive pair, so min mode has something to find
	assign adc_rx_o = (drive_w != 8'h00 && pair_rx_i) ? drive_w : (echo_w ? 8'hc0 : 8'hfe);
endmodule : crc_line_model

// ### tb_top.sv
// Self-checking testbench for the cable reflectometry controller
`timescale 1ns/100ps
module tb_top;
	import crc_pkg::*;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	localparam int ECHO_DLY = 20;
	// Busy rises with the run, so the model count tracks the timer; add two sync flops
	localparam logic [7:0] ECHO_T = 8'(ECHO_DLY + 2);
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [2:0] reg_page_i = 3'h0;
	logic [4:0] reg_addr_i = 5'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic [7:0] thr_level_i = 8'h7f;
	logic [15:0] reg_rdata_o;
	logic [7:0] adc_tx_w;
	logic [7:0] adc_rx_w;
	logic link_suspend_o, slow_own_o, fast_own_o, slow_pulse_o, pos_o, neg_o, pair_rx_o, busy_o;
	int bad_count = 0;
	int cmp_count = 0;
	int pos_cyc = 0;
	int neg_cyc = 0;
	int slow_cyc = 0;
	logic [15:0] d;

	always #(CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;

	crc_ctrl dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_page_i(reg_page_i),
		.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .adc_tx_pair_i(adc_tx_w),
		.adc_rx_pair_i(adc_rx_w), .thr_level_i(thr_level_i), .link_suspend_o(link_suspend_o),
		.slow_line_driver_own_o(slow_own_o), .fast_line_driver_own_o(fast_own_o),
		.slow_line_driver_pulse_o(slow_pulse_o), .fast_line_driver_pos_o(pos_o),
		.fast_line_driver_neg_o(neg_o), .pulse_pair_rx_o(pair_rx_o), .busy_o(busy_o));

	crc_line_model #(.ECHO_DLY(ECHO_DLY)) cable (.ref_clk_i(ref_clk_i), .busy_i(busy_o),
		.slow_pulse_i(slow_pulse_o), .fast_pos_i(pos_o), .fast_neg_i(neg_o),
		.pair_rx_i(pair_rx_o), .adc_tx_o(adc_tx_w), .adc_rx_o(adc_rx_w));

	// Pulse widths are measured in whole clocks
	always @(posedge ref_clk_i) begin
		if (pos_o === 1'b1) pos_cyc++;
		if (neg_o === 1'b1) neg_cyc++;
		if (slow_pulse_o === 1'b1) slow_cyc++;
	end

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk16

	task automatic chk_cnt(input int got, input int exp, input string what);
		cmp_count++;
		if (got != exp) begin
			bad_count++;
			$display("wrong value at %0t: %s count %0d expected %0d", $time, what, got, exp);
		end
	endtask : chk_cnt

	task automatic reg_wr(input logic [4:0] addr, input logic [15:0] data);
		@(negedge ref_clk_i);
		reg_page_i = DIAG_PAGE;
		reg_addr_i = addr;
		reg_wdata_i = data;
		reg_wr_i = 1'b1;
		@(negedge ref_clk_i);
		reg_wr_i = 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [2:0] page, input logic [4:0] addr, output logic [15:0] q);
		@(negedge ref_clk_i);
		reg_page_i = page;
		reg_addr_i = addr;
		reg_rd_i = 1'b1;
		@(negedge ref_clk_i);
		reg_rd_i = 1'b0;
		@(negedge ref_clk_i);
		q = reg_rdata_o;
	endtask : reg_rd

	// Launch one run with the driver handed over, wait for it to finish
	task automatic run(input logic [15:0] ctrl, input logic [15:0] win);
		int n;
		reg_wr(REG_WIN_OFS, win);
		pos_cyc = 0;
		neg_cyc = 0;
		slow_cyc = 0;
		reg_wr(REG_CTRL_OFS, ctrl | 16'h8800);
		n = 0;
		while (busy_o !== 1'b1 && n < 8) begin
			@(negedge ref_clk_i);
			n++;
		end
		chk16({15'h0000, busy_o}, 16'h0001, "busy after launch");
		n = 0;
		while (busy_o !== 1'b0 && n < 600) begin
			@(negedge ref_clk_i);
			n++;
		end
		chk16({15'h0000, busy_o}, 16'h0000, "busy at end");
		repeat (2) @(negedge ref_clk_i);
	endtask : run

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset;
		reg_rd(DIAG_PAGE, REG_CTRL_OFS, d);
		chk16(d, 16'h0000, "control reset");
		reg_rd(DIAG_PAGE, REG_WIN_OFS, d);
		chk16(d, 16'h00ff, "window reset");
		reg_rd(DIAG_PAGE, 5'h1a, d);
		chk16(d, 16'h0000, "unmapped offset");
		reg_wr(REG_CTRL_OFS, 16'h8000);
		reg_rd(3'h1, REG_CTRL_OFS, d);
		chk16(d, 16'h0000, "wrong page");
	endtask : t_reset

	task automatic t_enable;
		reg_wr(REG_CTRL_OFS, 16'h0800);
		repeat (6) @(negedge ref_clk_i);
		chk16({15'h0000, busy_o}, 16'h0000, "launch without enable");
		reg_wr(REG_CTRL_OFS, 16'h8000);
		@(negedge ref_clk_i);
		chk16({13'h0000, link_suspend_o, slow_own_o, fast_own_o}, 16'h0007, "owners");
	endtask : t_enable

	// Window start keeps the outgoing pulse on the monitored pair out
	task automatic t_fast;
		thr_level_i = 8'h30;
		run(16'h4300, 16'h0828);
		chk_cnt(pos_cyc, 3, "positive pulse");
		chk_cnt(neg_cyc + slow_cyc, 0, "other drivers");
		reg_rd(DIAG_PAGE, REG_PEAK_OFS, d);
		chk16(d, {ECHO_T, 8'h40}, "peak after window");
		reg_rd(DIAG_PAGE, REG_THR_OFS, d);
		chk16(d, {ECHO_T, 8'h40}, "threshold crossing");
		reg_rd(DIAG_PAGE, REG_CTRL_OFS, d);
		chk16(d, 16'hc300, "send bit clears");
	endtask : t_fast

	task automatic t_neg;
		thr_level_i = 8'he0;
		run(16'h5380, {ECHO_T, ECHO_T});
		chk_cnt(neg_cyc, 3, "negative pulse");
		chk_cnt(pos_cyc, 0, "no positive pulse");
		reg_rd(DIAG_PAGE, REG_PEAK_OFS, d);
		chk16(d, {ECHO_T, 8'hc0}, "min peak receive pair");
		reg_rd(DIAG_PAGE, REG_THR_OFS, d);
		chk16(d, {ECHO_T, 8'hc0}, "min threshold");
	endtask : t_neg

	task automatic t_slow;
		logic [2:0] w;
		for (int i = 0; i < 2; i++) begin
			w = (i == 0) ? 3'h2 : 3'h5;
			run(16'h2000 | {5'h00, w, 8'h00}, 16'h0028);
			chk_cnt(slow_cyc, (w < 3'h4) ? 2 : 5, "link pulse");
			chk_cnt(pos_cyc + neg_cyc, 0, "fast driver idle");
			chk16({15'h0000, pair_rx_o}, 16'h0001, "pulse pair");
			reg_rd(DIAG_PAGE, REG_PEAK_OFS, d);
			chk16(d, {ECHO_T, 8'h40}, "pulse kept off transmit pair");
		end
	endtask : t_slow

	task automatic t_zero;
		thr_level_i = 8'h7f;
		run(16'h4000, 16'h0028);
		chk_cnt(pos_cyc + neg_cyc + slow_cyc, 0, "no pulse");
		reg_rd(DIAG_PAGE, REG_PEAK_OFS, d);
		chk16(d, {ECHO_T, 8'h40}, "baseline peak");
		reg_rd(DIAG_PAGE, REG_THR_OFS, d);
		chk16(d, 16'h0000, "old crossing cleared");
	endtask : t_zero

	// ------------------------------------------------------------------
	// Sequence and verdict
	// ------------------------------------------------------------------
	task automatic stop_test;
		$display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test

	initial begin
		repeat (16) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		t_reset;
		t_enable;
		t_fast;
		t_neg;
		t_slow;
		t_zero;
		stop_test;
	end

	// Five runs of at most a few hundred clocks each fit well inside this
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		bad_count++;
		stop_test;
	end
endmodule : tb_top
